// ==== i2c_slave_addr_match_fifo_status_bench.sv ====
// Self-checking bench for the I2C slave: registers, address compare, stretch, FIFO levels.
// Assumes i2cm_slave, i2cm_master_model and the register map header.
`timescale 1ns/1ps
`default_nettype none
`include "i2cm_map.svh"
`define CHK(g, e) check_eq(8'(g), 8'(e))
module i2c_slave_addr_match_fifo_status_bench;
   logic       ref_clk;
   logic       reset_n;
   logic [7:0] reg_addr;
   logic [7:0] reg_wdata;
   logic       reg_wr;
   logic       reg_rd;
   logic [7:0] reg_rdata;
   logic       irq;
   logic       scl_out, scl_oe_n, sda_out, sda_oe_n;
   logic       scl, sda, m_scl_low, m_sda_low, ack;
   logic [7:0] rd, own, msk, a, b;
   logic [7:0] q[$];
   int         errors, checks_done, cycles;
   // ****
   // Wires with pull-ups
   // ****
   assign scl = !m_scl_low && (scl_oe_n || scl_out);
   assign sda = !m_sda_low && (sda_oe_n || sda_out);
   i2cm_slave dut_u (.ref_clk(ref_clk), .reset_n(reset_n), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .irq(irq), .scl_in(scl), .scl_out(scl_out), .scl_oe_n(scl_oe_n), .sda_in(sda),
      .sda_out(sda_out), .sda_oe_n(sda_oe_n));
   i2cm_master_model m_u (.scl(scl), .sda(sda), .scl_low(m_scl_low), .sda_low(m_sda_low));
   initial begin
      ref_clk = 1'b0;
      forever #2.5 ref_clk = ~ref_clk;
   end
   // ****
   // Helpers
   // ****
   task automatic test_done();
      if (errors == 0 && checks_done > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask
   always @(posedge ref_clk) begin
      cycles = cycles + 1;
      if (cycles == 20000) begin
         errors = errors + 1;
         test_done();
      end
   end
   task automatic check_eq(input logic [7:0] g, input logic [7:0] e);
      checks_done++;
      if (g !== e) begin
         errors++;
         $display("unexpected at %0t: got %h expected %h", $time, g, e);
      end
   endtask
   task automatic reg_write(input logic [7:0] ad, input logic [7:0] wd);
      @(posedge ref_clk);
      reg_addr  <= ad;
      reg_wdata <= wd;
      reg_wr    <= 1'b1;
      @(posedge ref_clk);
      reg_wr    <= 1'b0;
   endtask
   task automatic reg_read(input logic [7:0] ad);
      @(posedge ref_clk);
      reg_addr <= ad;
      reg_rd   <= 1'b1;
      @(posedge ref_clk);
      reg_rd   <= 1'b0;
      #1 rd = reg_rdata;
   endtask
   function automatic logic exp_match(logic [6:0] ad, logic [6:0] ow, logic [6:0] m);
      return ((ad ^ ow) & m) == 7'h00;
   endfunction
   function automatic logic [7:0] counts(int tx, int rx);
      return {1'b0, 3'(tx), 1'b0, 3'(rx)};
   endfunction
   // Byte whose transfer the slave stretches until the flag is cleared
   task automatic stretched_byte(input logic [7:0] d);
      logic k;
      fork
         m_u.write_byte(d, k);
         begin
            // Long enough for the 8th fall of a data byte to start the stretch
            repeat (100) @(posedge ref_clk);
            `CHK(scl, 1'b0);
            reg_read(`I2CM_CTRL_ADDR);
            `CHK(rd[0], 1'b1);
            reg_write(`I2CM_CTRL_ADDR, 8'h00);
         end
      join
      `CHK(k, 1'b1);
   endtask
   // ****
   // Main sequence
   // ****
   initial begin
      reset_n = 1'b0;
      reg_addr = 8'h00;
      reg_wdata = 8'h00;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      errors = 0;
      checks_done = 0;
      cycles = 0;
      void'($urandom(49));
      repeat (4) @(posedge ref_clk);
      reset_n <= 1'b1;
      repeat (4) @(posedge ref_clk);
      reg_read(`I2CM_FCT_ADDR);
      `CHK(rd, 8'h00);
      reg_read(`I2CM_ADM_ADDR);
      `CHK(rd, 8'hff);
      reg_read(8'h10);
      `CHK(rd, 8'h00);
      `CHK(irq, 1'b0);
      `CHK(scl_out | sda_out, 1'b0);
      repeat (4) begin
         a = $urandom;
         reg_write(`I2CM_ADM_ADDR, a);
         reg_read(`I2CM_ADM_ADDR);
         `CHK(rd, a);
      end
      reg_write(`I2CM_FCT_ADDR, 8'h77);
      reg_read(`I2CM_FCT_ADDR);
      `CHK(rd, 8'h00);
      // Masked address compare, forced stretch off
      own = $urandom & 8'h7f;
      reg_write(`I2CM_OWN_ADDR, own);
      for (int i = 0; i < 10; i++) begin
         msk = (i == 0) ? 8'h00 : (i == 1) ? 8'h7f : $urandom & 8'h7f;
         a = (i % 2) ? own ^ (8'h01 << ($urandom % 7)) : $urandom & 8'h7f;
         a = (i == 1) ? own : a;
         reg_write(`I2CM_ADM_ADDR, msk);
         m_u.start();
         m_u.write_byte({a[6:0], 1'b0}, ack);
         m_u.stop();
         `CHK(ack, exp_match(a[6:0], own[6:0], msk[6:0]));
         reg_read(`I2CM_CTRL_ADDR);
         `CHK(rd[0], 1'b0);
         `CHK(irq, 1'b0);
      end
      // Receive FIFO filled to refusal, forced stretch off
      reg_write(`I2CM_ADM_ADDR, 8'h7f);
      m_u.start();
      m_u.write_byte({own[6:0], 1'b0}, ack);
      `CHK(ack, 1'b1);
      repeat (3) begin
         a = $urandom;
         q.push_back(a);
         m_u.write_byte(a, ack);
         `CHK(ack, 1'b1);
      end
      reg_read(`I2CM_CTRL_ADDR);
      `CHK(rd[0], 1'b0);
      reg_read(`I2CM_FCT_ADDR);
      `CHK(rd, counts(0, 3));
      a = $urandom;
      q.push_back(a);
      stretched_byte(a);
      m_u.write_byte($urandom, ack);
      `CHK(ack, 1'b0);
      m_u.stop();
      reg_read(`I2CM_FCT_ADDR);
      `CHK(rd, counts(0, 4));
      repeat (4) begin
         reg_read(`I2CM_DATA_ADDR);
         `CHK(rd, q.pop_front());
      end
      reg_read(`I2CM_DATA_ADDR);
      `CHK(rd, 8'h00);
      reg_read(`I2CM_FCT_ADDR);
      `CHK(rd, counts(0, 0));
      // Forced stretch on, address interrupt unmasked, raised and cleared
      reg_read(`I2CM_STAT_ADDR);
      reg_write(`I2CM_IMASK_ADDR, 8'h01);
      reg_write(`I2CM_ADM_ADDR, 8'hff);
      m_u.start();
      m_u.write_byte({own[6:0], 1'b0}, ack);
      `CHK(ack, 1'b1);
      repeat (10) @(posedge ref_clk);
      `CHK(irq, 1'b1);
      reg_read(`I2CM_STAT_ADDR);
      `CHK(rd & 8'h01, 8'h01);
      repeat (3) @(posedge ref_clk);
      `CHK(irq, 1'b0);
      a = $urandom;
      stretched_byte(a);
      m_u.stop();
      `CHK(irq, 1'b0);
      reg_read(`I2CM_DATA_ADDR);
      `CHK(rd, a);
      // Transmit FIFO filled to refusal, then read by the master
      reg_write(`I2CM_ADM_ADDR, 8'h7f);
      for (int i = 0; i < 5; i++) begin
         a = $urandom;
         if (i < 4) q.push_back(a);
         reg_write(`I2CM_DATA_ADDR, a);
      end
      reg_read(`I2CM_FCT_ADDR);
      `CHK(rd, counts(4, 0));
      m_u.start();
      m_u.write_byte({own[6:0], 1'b1}, ack);
      `CHK(ack, 1'b1);
      m_u.read_byte(1'b1, b);
      `CHK(b, q.pop_front());
      m_u.read_byte(1'b0, b);
      `CHK(b, q.pop_front());
      m_u.stop();
      reg_read(`I2CM_FCT_ADDR);
      `CHK(rd, counts(2, 0));
      test_done();
   end
endmodule
`default_nettype wire

// ==== i2cm_addr_match.sv ====
// Masked compare of an incoming 7-bit address against the own address.
// Assumes all inputs are stable register values on the caller's clock.
`timescale 1ns/1ps
`default_nettype none
module i2cm_addr_match (
   input  wire logic [6:0] addr_in,
   input  wire logic [6:0] own_addr,
   input  wire logic [6:0] cmp_mask,
   output logic            match
);
   // Mask bit 1 compares, mask bit 0 ignores the incoming bit
   assign match = ((addr_in ^ own_addr) & cmp_mask) == 7'h00;
endmodule
`default_nettype wire

// ==== i2cm_map.svh ====
// Offsets, field positions, reset values and counts for the I2C slave block.
// Assumes inclusion by bare name from the design files.
`ifndef I2CM_MAP_SVH
`define I2CM_MAP_SVH
// ***********************
// Register offsets
// ***********************
`define I2CM_OWN_ADDR    8'hf4
`define I2CM_FCT_ADDR    8'hf5
`define I2CM_CTRL_ADDR   8'hf6
`define I2CM_DATA_ADDR   8'hf7
`define I2CM_STAT_ADDR   8'hf8
`define I2CM_IMASK_ADDR  8'hf9
`define I2CM_ADM_ADDR    8'hff
// ***********************
// Fields and reset values
// ***********************
`define I2CM_TX_FIFO_LEVEL_MSB   6
`define I2CM_TX_FIFO_LEVEL_LSB   4
`define I2CM_RX_FIFO_LEVEL_MSB   2
`define I2CM_RX_FIFO_LEVEL_LSB   0
`define I2CM_FORCE_BIT   7
`define I2CM_FORCE_RESET 1'b1
`define I2CM_MASK_RESET  7'h7f
`define I2CM_OWN_RESET   7'h00
`define I2CM_FLAG_BIT    0
`define I2CM_EV_ADDR     0
`define I2CM_EV_RX       1
`define I2CM_EV_STOP     2
`define I2CM_EV_FLAG     3
`define I2CM_NEV         4
// ***********************
// Counts
// ***********************
`define I2CM_FIFO_DEPTH  3'h4
`define I2CM_BIT_LAST    4'h8
`define I2CM_IDLE_BYTE   8'hff
`endif

// ==== i2cm_master_model.sv ====
// I2C bus master model that addresses the slave, with open-drain drive of SCL and SDA.
// Assumes the bench resolves both wires with pull-ups and feeds them back here.
`timescale 1ns/1ps
`default_nettype none
module i2cm_master_model (
   input  wire logic scl,
   input  wire logic sda,
   output logic      scl_low,
   output logic      sda_low
);
   // ****
   // Bus timing, quarter of a 48 ns bit
   // ****
   localparam time T = 12ns;
   initial begin
      scl_low = 1'b0;
      sda_low = 1'b0;
   end
   // Released clock waits out any stretch by the slave
   task automatic bit_cycle(input logic b, output logic q);
      sda_low = !b;
      #T;
      scl_low = 1'b0;
      wait (scl === 1'b1);
      #(2*T);
      q = sda;
      scl_low = 1'b1;
      #T;
   endtask
   // Also serves as repeated start
   task automatic start();
      sda_low = 1'b0;
      #T;
      scl_low = 1'b0;
      wait (scl === 1'b1);
      #(2*T);
      sda_low = 1'b1;
      #(2*T);
      scl_low = 1'b1;
      #T;
   endtask
   task automatic stop();
      sda_low = 1'b1;
      #T;
      scl_low = 1'b0;
      wait (scl === 1'b1);
      #(2*T);
      sda_low = 1'b0;
      #(4*T);
   endtask
   task automatic write_byte(input logic [7:0] d, output logic ack);
      logic q;
      for (int i = 7; i >= 0; i--) begin
         bit_cycle(d[i], q);
      end
      bit_cycle(1'b1, q);
      ack = !q;
   endtask
   task automatic read_byte(input logic ack, output logic [7:0] d);
      logic q;
      for (int i = 7; i >= 0; i--) begin
         bit_cycle(1'b1, q);
         d[i] = q;
      end
      bit_cycle(!ack, q);
   endtask
endmodule
`default_nettype wire

// ==== i2cm_pkg.sv ====
// Types shared by the I2C slave block.
// Assumes nothing beyond a SystemVerilog compiler.
package i2cm_pkg;
   typedef enum logic [6:0] {
      I2CM_IDLE     = 7'h01,
      I2CM_ADDR     = 7'h02,
      I2CM_ADDR_ACK = 7'h04,
      I2CM_RX       = 7'h08,
      I2CM_RX_ACK   = 7'h10,
      I2CM_TX       = 7'h20,
      I2CM_TX_ACK   = 7'h40
   } i2cm_state_type;
   typedef logic [2:0] i2cm_level_type;
endpackage

// ==== i2cm_slave.sv ====
// I2C slave: address match under mask, forced stretch, FIFO counts, registers.
// Assumes scl/sda pins arrive asynchronously and the bus wire is resolved outside.
`timescale 1ns/1ps
`default_nettype none
`include "i2cm_map.svh"
module i2cm_slave (
   input  wire logic       ref_clk,
   input  wire logic       reset_n,
   input  wire logic [7:0] reg_addr,
   input  wire logic [7:0] reg_wdata,
   input  wire logic       reg_wr,
   input  wire logic       reg_rd,
   output logic      [7:0] reg_rdata,
   output logic            irq,
   input  wire logic       scl_in,
   output logic            scl_out,
   output logic            scl_oe_n,
   input  wire logic       sda_in,
   output logic            sda_out,
   output logic            sda_oe_n
);
   // ***********************
   // Declarations
   // ***********************
   i2cm_pkg::i2cm_state_type state;
   i2cm_pkg::i2cm_level_type rx_level;
   i2cm_pkg::i2cm_level_type tx_level;
   logic                     scl_meta, scl_sync, scl_prev;
   logic                     sda_meta, sda_sync, sda_prev;
   logic                     scl_rise, scl_fall, bus_start, bus_stop;
   logic [3:0]               bit_cnt;
   logic [7:0]               shreg;
   logic                     rw, master_ack;
   logic                     force_addr_stretch;
   logic [6:0]               addr_compare_mask;
   logic [6:0]               own_slave_address;
   logic                     slave_irq_flag;
   logic                     addr_match, addr_end, ack_done, tx_load, rx_byte;
   logic                     rx_room, rx_push, rx_pop, tx_push, tx_pop, flag_set;
   logic [7:0]               rx_mem [0:3];
   logic [7:0]               tx_mem [0:3];
   logic [1:0]               rx_wp, rx_rp, tx_wp, tx_rp;
   logic [7:0]               tx_byte;
   logic [`I2CM_NEV-1:0]     int_status, int_mask, events;
   logic [7:0]               next_rdata;
   logic                     wr_ctrl, rd_stat;

   function automatic i2cm_pkg::i2cm_level_type level_step(
      input i2cm_pkg::i2cm_level_type level,
      input logic                     push,
      input logic                     pop);
      i2cm_pkg::i2cm_level_type res;
      res = level;
      if (push && !pop) begin
         res = level + 3'h1;
      end else if (pop && !push) begin
         res = level - 3'h1;
      end
      return res;
   endfunction

   // ***********************
   // Pin synchronisers
   // ***********************
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         scl_meta <= 1'b1;
         scl_sync <= 1'b1;
         scl_prev <= 1'b1;
         sda_meta <= 1'b1;
         sda_sync <= 1'b1;
         sda_prev <= 1'b1;
      end else begin
         scl_meta <= scl_in;
         scl_sync <= scl_meta;
         scl_prev <= scl_sync;
         sda_meta <= sda_in;
         sda_sync <= sda_meta;
         sda_prev <= sda_sync;
      end
   end

   assign scl_rise  = scl_sync & ~scl_prev;
   assign scl_fall  = ~scl_sync & scl_prev;
   assign bus_start = scl_sync & scl_prev & sda_prev & ~sda_sync;
   assign bus_stop  = scl_sync & scl_prev & ~sda_prev & sda_sync;

   // ***********************
   // Transfer events
   // ***********************
   i2cm_addr_match u_match (
      .addr_in  (shreg[7:1]),
      .own_addr (own_slave_address),
      .cmp_mask (addr_compare_mask),
      .match    (addr_match)
   );

   assign addr_end = scl_fall && state == i2cm_pkg::I2CM_ADDR && bit_cnt == `I2CM_BIT_LAST;
   assign ack_done = scl_fall && state == i2cm_pkg::I2CM_ADDR_ACK;
   assign tx_load  = scl_fall && ((state == i2cm_pkg::I2CM_ADDR_ACK && rw) ||
                                  (state == i2cm_pkg::I2CM_TX_ACK && master_ack));
   assign rx_byte  = scl_fall && state == i2cm_pkg::I2CM_RX && bit_cnt == `I2CM_BIT_LAST;
   assign rx_room  = rx_level != `I2CM_FIFO_DEPTH;
   assign rx_push  = rx_byte && rx_room;
   assign rx_pop   = reg_rd && reg_addr == `I2CM_DATA_ADDR && rx_level != 3'h0;
   assign tx_push  = reg_wr && reg_addr == `I2CM_DATA_ADDR && tx_level != `I2CM_FIFO_DEPTH;
   assign tx_pop   = tx_load && tx_level != 3'h0;
   assign tx_byte  = (tx_level != 3'h0) ? tx_mem[tx_rp] : `I2CM_IDLE_BYTE;
   assign wr_ctrl  = reg_wr && reg_addr == `I2CM_CTRL_ADDR;
   assign rd_stat  = reg_rd && reg_addr == `I2CM_STAT_ADDR;

   // Forced by address ack, or by a starved read or a filled receive FIFO
   assign flag_set = (ack_done && force_addr_stretch) ||
                     (tx_load && tx_level == 3'h0) ||
                     (rx_push && rx_level == `I2CM_FIFO_DEPTH - 3'h1);

   // ***********************
   // Link state machine
   // ***********************
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         state      <= i2cm_pkg::I2CM_IDLE;
         bit_cnt    <= 4'h0;
         shreg      <= 8'h00;
         rw         <= 1'b0;
         master_ack <= 1'b0;
         sda_oe_n   <= 1'b1;
      end else if (bus_start) begin
         state    <= i2cm_pkg::I2CM_ADDR;
         bit_cnt  <= 4'h0;
         sda_oe_n <= 1'b1;
      end else if (bus_stop) begin
         state    <= i2cm_pkg::I2CM_IDLE;
         sda_oe_n <= 1'b1;
      end else if (scl_rise) begin
         case (state)
            i2cm_pkg::I2CM_ADDR, i2cm_pkg::I2CM_RX: begin
               shreg   <= {shreg[6:0], sda_sync};
               bit_cnt <= bit_cnt + 4'h1;
            end
            i2cm_pkg::I2CM_TX_ACK: begin
               master_ack <= ~sda_sync;
            end
            default: begin
            end
         endcase
      end else if (scl_fall) begin
         case (state)
            i2cm_pkg::I2CM_ADDR: begin
               if (bit_cnt == `I2CM_BIT_LAST) begin
                  if (addr_match) begin
                     state    <= i2cm_pkg::I2CM_ADDR_ACK;
                     sda_oe_n <= 1'b0;
                     rw       <= shreg[0];
                  end else begin
                     state <= i2cm_pkg::I2CM_IDLE;
                  end
               end
            end
            i2cm_pkg::I2CM_ADDR_ACK, i2cm_pkg::I2CM_TX_ACK: begin
               if (tx_load) begin
                  state    <= i2cm_pkg::I2CM_TX;
                  sda_oe_n <= tx_byte[7];
                  shreg    <= {tx_byte[6:0], 1'b1};
                  bit_cnt  <= 4'h1;
               end else if (state == i2cm_pkg::I2CM_ADDR_ACK) begin
                  state    <= i2cm_pkg::I2CM_RX;
                  sda_oe_n <= 1'b1;
                  bit_cnt  <= 4'h0;
               end else begin
                  state    <= i2cm_pkg::I2CM_IDLE;
                  sda_oe_n <= 1'b1;
               end
            end
            i2cm_pkg::I2CM_TX: begin
               if (bit_cnt == `I2CM_BIT_LAST) begin
                  state    <= i2cm_pkg::I2CM_TX_ACK;
                  sda_oe_n <= 1'b1;
               end else begin
                  sda_oe_n <= shreg[7];
                  shreg    <= {shreg[6:0], 1'b1};
                  bit_cnt  <= bit_cnt + 4'h1;
               end
            end
            i2cm_pkg::I2CM_RX: begin
               if (bit_cnt == `I2CM_BIT_LAST) begin
                  state    <= i2cm_pkg::I2CM_RX_ACK;
                  // Full receive FIFO answers with a nack
                  sda_oe_n <= ~rx_room;
               end
            end
            i2cm_pkg::I2CM_RX_ACK: begin
               state    <= i2cm_pkg::I2CM_RX;
               sda_oe_n <= 1'b1;
               bit_cnt  <= 4'h0;
            end
            default: begin
            end
         endcase
      end
   end

   // ***********************
   // Flag and clock stretch
   // ***********************
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         slave_irq_flag <= 1'b0;
      end else if (flag_set) begin
         slave_irq_flag <= 1'b1;
      end else if (wr_ctrl && !reg_wdata[`I2CM_FLAG_BIT]) begin
         slave_irq_flag <= 1'b0;
      end
   end

   // Clock held low while the flag stands inside a transfer
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         scl_oe_n <= 1'b1;
         scl_out  <= 1'b0;
         sda_out  <= 1'b0;
      end else begin
         scl_oe_n <= ~(slave_irq_flag && state != i2cm_pkg::I2CM_IDLE);
         scl_out  <= 1'b0;
         sda_out  <= 1'b0;
      end
   end

   // ***********************
   // FIFOs
   // ***********************
   always_ff @(posedge ref_clk) begin
      if (rx_push) begin
         rx_mem[rx_wp] <= shreg;
      end
      if (tx_push) begin
         tx_mem[tx_wp] <= reg_wdata;
      end
   end

   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         rx_wp    <= 2'h0;
         rx_rp    <= 2'h0;
         tx_wp    <= 2'h0;
         tx_rp    <= 2'h0;
         rx_level <= 3'h0;
         tx_level <= 3'h0;
      end else begin
         rx_wp    <= rx_wp + {1'b0, rx_push};
         rx_rp    <= rx_rp + {1'b0, rx_pop};
         tx_wp    <= tx_wp + {1'b0, tx_push};
         tx_rp    <= tx_rp + {1'b0, tx_pop};
         rx_level <= level_step(rx_level, rx_push, rx_pop);
         tx_level <= level_step(tx_level, tx_push, tx_pop);
      end
   end

   // ***********************
   // Registers
   // ***********************
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         force_addr_stretch <= `I2CM_FORCE_RESET;
         addr_compare_mask  <= `I2CM_MASK_RESET;
         own_slave_address  <= `I2CM_OWN_RESET;
         int_mask           <= '0;
      end else if (reg_wr) begin
         if (reg_addr == `I2CM_ADM_ADDR) begin
            force_addr_stretch <= reg_wdata[`I2CM_FORCE_BIT];
            addr_compare_mask  <= reg_wdata[6:0];
         end else if (reg_addr == `I2CM_OWN_ADDR) begin
            own_slave_address <= reg_wdata[6:0];
         end else if (reg_addr == `I2CM_IMASK_ADDR) begin
            int_mask <= reg_wdata[`I2CM_NEV-1:0];
         end
      end
   end

   always_comb begin
      events                = '0;
      events[`I2CM_EV_ADDR] = ack_done;
      events[`I2CM_EV_RX]   = rx_push;
      events[`I2CM_EV_STOP] = bus_stop && state != i2cm_pkg::I2CM_IDLE;
      events[`I2CM_EV_FLAG] = flag_set;
   end

   // New events win over the clear of a status read
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         int_status <= '0;
         irq        <= 1'b0;
      end else begin
         int_status <= (rd_stat ? '0 : int_status) | events;
         irq        <= |(int_status & int_mask);
      end
   end

   always_comb begin
      next_rdata = 8'h00;
      if (reg_addr == `I2CM_FCT_ADDR) begin
         next_rdata[`I2CM_TX_FIFO_LEVEL_MSB:`I2CM_TX_FIFO_LEVEL_LSB] = tx_level;
         next_rdata[`I2CM_RX_FIFO_LEVEL_MSB:`I2CM_RX_FIFO_LEVEL_LSB] = rx_level;
      end else if (reg_addr == `I2CM_ADM_ADDR) begin
         next_rdata = {force_addr_stretch, addr_compare_mask};
      end else if (reg_addr == `I2CM_OWN_ADDR) begin
         next_rdata = {1'b0, own_slave_address};
      end else if (reg_addr == `I2CM_CTRL_ADDR) begin
         next_rdata[`I2CM_FLAG_BIT] = slave_irq_flag;
      end else if (reg_addr == `I2CM_DATA_ADDR) begin
         next_rdata = (rx_level != 3'h0) ? rx_mem[rx_rp] : 8'h00;
      end else if (reg_addr == `I2CM_STAT_ADDR) begin
         next_rdata[`I2CM_NEV-1:0] = int_status;
      end else if (reg_addr == `I2CM_IMASK_ADDR) begin
         next_rdata[`I2CM_NEV-1:0] = int_mask;
      end
   end

   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         reg_rdata <= 8'h00;
      end else begin
         reg_rdata <= reg_rd ? next_rdata : 8'h00;
      end
   end

   // ***********************
   // Assertions
   // ***********************
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!reset_n);

   sequence seq_fct_read;
      reg_rd && reg_addr == `I2CM_FCT_ADDR;
   endsequence
   sequence seq_stretch_on;
      slave_irq_flag && state != i2cm_pkg::I2CM_IDLE;
   endsequence

   a_tx_level_read: assert property (seq_fct_read |=> reg_rdata[6:4] == $past(tx_level))
      else $error("tx level misread");
   a_rx_level_read: assert property (seq_fct_read |=> reg_rdata[2:0] == $past(rx_level))
      else $error("rx level misread");
   a_mask_readback: assert property (reg_wr && reg_addr == `I2CM_ADM_ADDR ##1 reg_rd && reg_addr == `I2CM_ADM_ADDR |=> reg_rdata == $past(reg_wdata, 2))
      else $error("mask register readback wrong");
   a_force_sets_flag: assert property (ack_done && force_addr_stretch |=> slave_irq_flag ##1 !scl_oe_n)
      else $error("forced stretch missing");
   a_stretch_until_clear: assert property (seq_stretch_on ##1 seq_stretch_on |-> !scl_oe_n)
      else $error("clock released while flag set");
   a_flag_clear_cause: assert property ($fell(slave_irq_flag) |-> $past(wr_ctrl && !reg_wdata[0]))
      else $error("flag cleared without firmware");
   a_no_forced_flag: assert property (ack_done && !force_addr_stretch && !slave_irq_flag && !flag_set |=> !slave_irq_flag)
      else $error("address ack set flag without force");
   a_starved_flag: assert property (tx_load && tx_level == 3'h0 |=> slave_irq_flag)
      else $error("starved read did not raise flag");
   a_match_acked: assert property (addr_end && addr_match |=> state == i2cm_pkg::I2CM_ADDR_ACK && !sda_oe_n)
      else $error("matching address not acked");
   a_mismatch_dropped: assert property (addr_end && !addr_match |=> state == i2cm_pkg::I2CM_IDLE && sda_oe_n)
      else $error("mismatching address acked");
   a_level_bound: assert property (rx_level <= `I2CM_FIFO_DEPTH && tx_level <= `I2CM_FIFO_DEPTH)
      else $error("fifo level out of range");
   a_level_step: assert property (rx_push && !rx_pop |=> rx_level == $past(rx_level) + 3'h1)
      else $error("rx level did not count up");
endmodule
`default_nettype wire
